// ===== src/plc_line_ctrl.sv
/*
 * Parallel line controller: 32 I/O lines with pull control, ownership
 * between general-purpose control and four peripheral functions, output
 * set/clear, masked direct output write, open-drain drive and pin readback,
 * all behind an AXI4-Lite slave.
 * Assumes pin inputs synchronous to aclk for the bus logic; pin levels are
 * still resynchronised before readback. clk_on stands for the gated
 * peripheral clock being enabled.
 */
`timescale 1ns/1ps

module plc_line_ctrl
    import plc_pkg::*;
#(
    parameter logic [31:0]                  OWN_RESET      = 32'hffff_ffff,
    parameter logic [31:0]                  PU_RESET       = 32'hffff_ffff,
    parameter logic [31:0]                  PD_RESET       = 32'hffff_ffff,
    parameter logic [PLC_FUNCS-1:0][31:0]   PERIPH_PRESENT = {32'h0000_00ff, 32'h0000_ffff,
                                                              32'h00ff_ffff, 32'h00ff_ffff}
) (
    input  wire logic                           aclk,         // peripheral clock
    input  wire logic                           aresetn,      // sync reset, active low
    input  wire logic                           clk_on,       // peripheral clock enabled
    input  wire plc_axil_req_t                  axi_req,      // bus requests
    output plc_axil_rsp_t                       axi_rsp,      // bus responses
    input  wire logic [PLC_LINES-1:0]           pin_in,       // pin levels
    output logic [PLC_LINES-1:0]                pin_out,      // pin output value
    output logic [PLC_LINES-1:0]                pin_oe,       // pin drive enable
    output logic [PLC_LINES-1:0]                pull_up_on,   // pull-up resistor on
    output logic [PLC_LINES-1:0]                pull_down_on, // pull-down resistor on
    input  wire logic [PLC_FUNCS-1:0][31:0]     periph_out,   // peripheral output values
    input  wire logic [PLC_FUNCS-1:0][31:0]     periph_oe,    // peripheral drive enables
    output logic [PLC_LINES-1:0]                periph_in,    // pin level to peripherals
    input  wire logic                           event_irq,    // raw event from detector
    output logic                                irq           // interrupt request
);

    typedef struct packed {
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] own;
        logic [31:0] fsel_lo;
        logic [31:0] fsel_hi;
        logic [31:0] oe;
        logic [31:0] odsr;
        logic [31:0] wmask;
        logic [31:0] md;
        logic [31:0] pu;
        logic [31:0] pd;
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] pdsr;
        logic [31:0] pin_out;
        logic [31:0] pin_oe;
        logic        irq;
    } plc_state_t;

    localparam logic [31:0] MUXED = PERIPH_PRESENT[0] | PERIPH_PRESENT[1] |
                                    PERIPH_PRESENT[2] | PERIPH_PRESENT[3];

    // gpio-only lines can never come out of reset peripheral owned
    localparam plc_state_t ST_RST = '{
        own:     OWN_RESET | ~MUXED,
        fsel_lo: PLC_FSEL_RST,
        fsel_hi: PLC_FSEL_RST,
        oe:      PLC_OE_RST,
        odsr:    PLC_OD_RST,
        wmask:   PLC_WMASK_RST,
        md:      PLC_MD_RST,
        pu:      PU_RESET,
        pd:      PD_RESET,
        default: '0
    };

    plc_state_t s_q;
    plc_state_t s_d;

    logic [31:0] sel_out;
    logic [31:0] sel_oe;

    for (genvar i = 0; i < PLC_LINES; i++) begin : g_line
        logic [1:0] code;
        assign code = {s_q.fsel_hi[i], s_q.fsel_lo[i]};
        assign sel_out[i] = periph_out[code][i];
        assign sel_oe[i]  = periph_oe[code][i] & PERIPH_PRESENT[code][i];
    end

    logic        wr_do;
    logic [31:0] wbits;
    logic [31:0] bmask;
    logic [31:0] drive_o;
    logic [31:0] drive_e;

    always_comb begin
        s_d   = s_q;
        bmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}}, {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
        wbits = s_q.w_data & bmask;
        wr_do = s_q.aw_full && s_q.w_full && !s_q.bvalid;

        // write channels, taken in either order
        if (axi_req.awvalid && !s_q.aw_full) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s_q.w_full) begin
            s_d.w_full = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end

        if (wr_do) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = PLC_RESP_OKAY;
            unique case (s_q.aw_addr)
                PLC_LINE_CTRL_EN:  s_d.own   = s_q.own | (wbits & MUXED);
                PLC_LINE_CTRL_DIS: s_d.own   = s_q.own & ~(wbits & MUXED);
                PLC_OE_SET:        s_d.oe    = s_q.oe | wbits;
                PLC_OE_CLR:        s_d.oe    = s_q.oe & ~wbits;
                PLC_OD_SET:        s_d.odsr  = s_q.odsr | wbits;
                PLC_OD_CLR:        s_d.odsr  = s_q.odsr & ~wbits;
                PLC_OD_STATUS:     s_d.odsr  = (s_q.odsr & ~(s_q.wmask & bmask)) |
                                               (s_q.w_data & s_q.wmask & bmask);
                PLC_MD_EN:         s_d.md    = s_q.md | wbits;
                PLC_MD_DIS:        s_d.md    = s_q.md & ~wbits;
                PLC_PU_EN:         s_d.pu    = s_q.pu & ~(wbits & s_q.pd);
                PLC_PU_DIS:        s_d.pu    = s_q.pu | wbits;
                PLC_PD_EN:         s_d.pd    = s_q.pd & ~(wbits & s_q.pu);
                PLC_PD_DIS:        s_d.pd    = s_q.pd | wbits;
                PLC_FSEL_LO:       s_d.fsel_lo = (s_q.fsel_lo & ~bmask) | wbits;
                PLC_FSEL_HI:       s_d.fsel_hi = (s_q.fsel_hi & ~bmask) | wbits;
                PLC_WMASK_EN:      s_d.wmask = s_q.wmask | wbits;
                PLC_WMASK_DIS:     s_d.wmask = s_q.wmask & ~wbits;
                PLC_OWN_STATUS, PLC_OE_STATUS, PLC_PIN_STATUS, PLC_MD_STATUS,
                PLC_PU_STATUS, PLC_PD_STATUS, PLC_WMASK_STATUS: s_d.bresp = PLC_RESP_OKAY;
                default:           s_d.bresp = PLC_RESP_SLVERR;
            endcase
        end

        // read channel: one read outstanding, answered right after the address
        if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (axi_req.arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = PLC_RESP_OKAY;
            unique case (axi_req.araddr)
                PLC_OWN_STATUS:   s_d.rdata = s_q.own;
                PLC_OE_STATUS:    s_d.rdata = s_q.oe;
                PLC_OD_STATUS:    s_d.rdata = s_q.odsr;
                PLC_PIN_STATUS:   s_d.rdata = s_q.pdsr;
                PLC_MD_STATUS:    s_d.rdata = s_q.md;
                PLC_PU_STATUS:    s_d.rdata = s_q.pu;
                PLC_PD_STATUS:    s_d.rdata = s_q.pd;
                PLC_FSEL_LO:      s_d.rdata = s_q.fsel_lo;
                PLC_FSEL_HI:      s_d.rdata = s_q.fsel_hi;
                PLC_WMASK_STATUS: s_d.rdata = s_q.wmask;
                PLC_LINE_CTRL_EN, PLC_LINE_CTRL_DIS, PLC_OE_SET, PLC_OE_CLR, PLC_OD_SET,
                PLC_OD_CLR, PLC_MD_EN, PLC_MD_DIS, PLC_PU_EN, PLC_PU_DIS, PLC_PD_EN,
                PLC_PD_DIS, PLC_WMASK_EN, PLC_WMASK_DIS: s_d.rdata = 32'h0000_0000;
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = PLC_RESP_SLVERR;
                end
            endcase
        end

        // sync1 is read only by sync2; the stopped clock freezes readback
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;
        if (clk_on) begin
            s_d.pdsr = s_q.sync2;
        end

        // a general-purpose owned line ignores the selected peripheral entirely
        drive_o = (s_q.own & s_q.odsr) | (~s_q.own & sel_out);
        drive_e = (s_q.own & s_q.oe)   | (~s_q.own & sel_oe);
        // next open-drain state, so a line never drives high for a cycle after it is set
        s_d.pin_out = drive_o & ~s_d.md;
        s_d.pin_oe  = drive_e & ~(s_d.md & drive_o);

        s_d.irq = event_irq & clk_on;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign axi_rsp.awready = !s_q.aw_full;
    assign axi_rsp.wready  = !s_q.w_full;
    assign axi_rsp.bvalid  = s_q.bvalid;
    assign axi_rsp.bresp   = s_q.bresp;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.rvalid  = s_q.rvalid;
    assign axi_rsp.rdata   = s_q.rdata;
    assign axi_rsp.rresp   = s_q.rresp;
    assign pin_out         = s_q.pin_out;
    assign pin_oe          = s_q.pin_oe;
    assign pull_up_on      = ~s_q.pu;
    assign pull_down_on    = ~s_q.pd;
    assign periph_in       = pin_in;
    assign irq             = s_q.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr(logic [7:0] a);
        wr_do && s_q.aw_addr == a;
    endsequence

    sequence s_clk_running;
        clk_on [*2];
    endsequence

    chk_irq_gated: assert property (irq |-> $past(clk_on))
        else $error("interrupt raised while clock gated");

    chk_pullup_block: assert property (s_wr(PLC_PU_EN) |=>
        ((s_q.pu ^ $past(s_q.pu)) & ~$past(s_q.pd)) == 32'h0000_0000)
        else $error("pull-up enabled over active pull-down");

    chk_pulldown_block: assert property (s_wr(PLC_PD_EN) |=>
        ((s_q.pd ^ $past(s_q.pd)) & ~$past(s_q.pu)) == 32'h0000_0000)
        else $error("pull-down enabled over active pull-up");

    chk_own_fixed: assert property ((s_q.own | MUXED) == 32'hffff_ffff)
        else $error("gpio-only line lost general purpose ownership");

    chk_periph_drive: assert property (
        (!s_q.own[0] && !s_q.md[0] && s_q.fsel_hi[0] && s_q.fsel_lo[0] && PERIPH_PRESENT[3][0])
        |=> pin_out[0] == $past(periph_out[3][0]) && pin_oe[0] == $past(periph_oe[3][0]))
        else $error("peripheral D output not steered to line 0");

    chk_masked_write: assert property (s_wr(PLC_OD_STATUS) && s_q.w_strb == 4'hf |=>
        ((s_q.odsr ^ $past(s_q.odsr)) & ~$past(s_q.wmask)) == 32'h0000_0000 &&
        (s_q.odsr & $past(s_q.wmask)) == ($past(s_q.w_data) & $past(s_q.wmask)))
        else $error("direct output write ignored the write mask");

    chk_open_drain: assert property ((s_q.md & pin_oe & pin_out) == 32'h0000_0000)
        else $error("open-drain line driven high");

    chk_oe_preset: assert property (s_wr(PLC_OE_SET) && s_q.w_strb == 4'hf |=>
        (s_q.oe & $past(s_q.w_data)) == $past(s_q.w_data))
        else $error("output enable set did not take effect");

    chk_pin_hold: assert property (!clk_on |=> $stable(s_q.pdsr))
        else $error("pin readback changed while clock gated");

    // the synchroniser flops restart from zero, so skip the first cycles after reset
    chk_pin_sync: assert property (clk_on && $past(aresetn) && $past(aresetn, 2)
        |=> s_q.pdsr == $past(pin_in, 3))
        else $error("pin readback latency is not three cycles");

    chk_bresp_time: assert property ((s_q.aw_full && s_q.w_full && !s_q.bvalid) |=> s_q.bvalid)
        else $error("write response missing after both channels taken");

    chk_readback_live: assert property (s_clk_running |=> s_q.pdsr == $past(s_q.sync2))
        else $error("pin readback not following synchroniser");

endmodule : plc_line_ctrl

// ===== src/plc_pkg.sv
/*
 * Shared constants and carrier types of the parallel line controller:
 * register byte offsets, reset values, bus response codes and the
 * AXI4-Lite request/response structs.
 * Assumes a 32-bit AXI4-Lite bus with an 8-bit byte address.
 */
package plc_pkg;

    localparam int          PLC_LINES = 32;
    localparam int          PLC_AW    = 8;
    localparam int          PLC_FUNCS = 4;

    // register byte offsets
    localparam logic [7:0]  PLC_LINE_CTRL_EN    = 8'h00;
    localparam logic [7:0]  PLC_LINE_CTRL_DIS   = 8'h04;
    localparam logic [7:0]  PLC_OWN_STATUS      = 8'h08;
    localparam logic [7:0]  PLC_OE_SET          = 8'h10;
    localparam logic [7:0]  PLC_OE_CLR          = 8'h14;
    localparam logic [7:0]  PLC_OE_STATUS       = 8'h18;
    localparam logic [7:0]  PLC_OD_SET          = 8'h30;
    localparam logic [7:0]  PLC_OD_CLR          = 8'h34;
    localparam logic [7:0]  PLC_OD_STATUS       = 8'h38;
    localparam logic [7:0]  PLC_PIN_STATUS      = 8'h3c;
    localparam logic [7:0]  PLC_MD_EN           = 8'h50;
    localparam logic [7:0]  PLC_MD_DIS          = 8'h54;
    localparam logic [7:0]  PLC_MD_STATUS       = 8'h58;
    localparam logic [7:0]  PLC_PU_EN           = 8'h60;
    localparam logic [7:0]  PLC_PU_DIS          = 8'h64;
    localparam logic [7:0]  PLC_PU_STATUS       = 8'h68;
    localparam logic [7:0]  PLC_FSEL_LO         = 8'h70;
    localparam logic [7:0]  PLC_FSEL_HI         = 8'h74;
    localparam logic [7:0]  PLC_PD_EN           = 8'h90;
    localparam logic [7:0]  PLC_PD_DIS          = 8'h94;
    localparam logic [7:0]  PLC_PD_STATUS       = 8'h98;
    localparam logic [7:0]  PLC_WMASK_EN        = 8'ha0;
    localparam logic [7:0]  PLC_WMASK_DIS       = 8'ha4;
    localparam logic [7:0]  PLC_WMASK_STATUS    = 8'ha8;

    // reset values
    localparam logic [31:0] PLC_OE_RST    = 32'h0000_0000;
    localparam logic [31:0] PLC_OD_RST    = 32'h0000_0000;
    localparam logic [31:0] PLC_WMASK_RST = 32'h0000_0000;
    localparam logic [31:0] PLC_MD_RST    = 32'h0000_0000;
    localparam logic [31:0] PLC_FSEL_RST  = 32'h0000_0000;

    localparam logic [1:0]  PLC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PLC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              awvalid;
        logic [PLC_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [PLC_AW-1:0] araddr;
        logic              rready;
    } plc_axil_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } plc_axil_rsp_t;

endpackage : plc_pkg

// ===== tb/parallel_io_line_controller_tb.sv
/*
 * Self-checking bench of the line controller: AXI4-Lite master tasks,
 * a read monitor fed from an expectation queue, pin and peripheral stimulus.
 * Assumes the default present masks of the design (lines 24..31 gpio only).
 */
`timescale 1ns/1ps
module parallel_io_line_controller_tb;
    import plc_pkg::*;
    localparam logic [31:0]       MUXED = 32'h00ff_ffff;
    localparam logic [3:0][31:0]  PRES  = {32'h0000_00ff, 32'h0000_ffff, 32'h00ff_ffff, 32'h00ff_ffff};
    logic             aclk, aresetn, clk_on, event_irq, irq;
    plc_axil_req_t    req;
    plc_axil_rsp_t    rsp;
    logic [31:0]      lvl, pin_out, pin_oe, pu_on, pd_on, periph_in, ext_val, ext_oe;
    logic [3:0][31:0] p_out, p_oe, po, pe;
    logic [33:0]      exp_q[$];
    int               mismatches, tests_run;
    logic [31:0]      r, v, m, ev, od, oe, md, e_oe;

    plc_line_ctrl i_dut (
        .aclk(aclk), .aresetn(aresetn), .clk_on(clk_on), .axi_req(req), .axi_rsp(rsp),
        .pin_in(lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_on(pu_on),
        .pull_down_on(pd_on), .periph_out(p_out), .periph_oe(p_oe), .periph_in(periph_in),
        .event_irq(event_irq), .irq(irq));
    plc_pin_model i_pins (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pu_on(pu_on),
        .pd_on(pd_on), .ext_val(ext_val), .ext_oe(ext_oe), .lvl(lvl));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = PLC_RESP_OKAY);
        bit aw, w, b;
        @(posedge aclk);
        {req.awvalid, req.wvalid, req.bready} <= 3'b111;
        req.awaddr <= a;
        req.wdata  <= d;
        req.wstrb  <= 4'hf;
        while (!b) begin
            @(negedge aclk);
            aw = aw | (req.awvalid & rsp.awready);
            w  = w | (req.wvalid & rsp.wready);
            b  = (rsp.bvalid === 1'b1);
            if (b) check(rsp.bresp, resp);
            @(posedge aclk);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            if (b) req.bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = PLC_RESP_OKAY);
        bit ar, rv;
        exp_q.push_back({resp, d});
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        while (!rv) begin
            @(negedge aclk);
            ar = ar | (req.arvalid & rsp.arready);
            rv = (rsp.rvalid === 1'b1);
            @(posedge aclk);
            if (ar) req.arvalid <= 1'b0;
            if (rv) req.rready <= 1'b0;
        end
    endtask : rd

    // read results are judged apart from the driver, oldest note first
    always @(negedge aclk) begin
        if (rsp.rvalid === 1'b1 && req.rready) begin
            if (exp_q.size() == 0)
                check(34'h0, 34'h3_ffff_ffff);
            else
                check({rsp.rresp, rsp.rdata}, exp_q.pop_front());
        end
    end

    initial begin
        repeat (3000) @(posedge aclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        {aresetn, event_irq, ext_val, ext_oe} = '0;
        clk_on = 1'b1;
        req    = '0;
        void'($urandom(53932));
        p_out  = {$urandom, $urandom, $urandom, $urandom};
        p_oe   = '1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(PLC_OWN_STATUS, 32'hffff_ffff);
        rd(PLC_OE_STATUS, PLC_OE_RST);
        rd(PLC_OD_STATUS, PLC_OD_RST);
        rd(PLC_MD_STATUS, PLC_MD_RST);
        rd(PLC_FSEL_LO, PLC_FSEL_RST);
        rd(PLC_FSEL_HI, PLC_FSEL_RST);
        rd(PLC_WMASK_STATUS, PLC_WMASK_RST);
        rd(PLC_LINE_CTRL_EN, 32'h0);
        rd(8'hfc, 32'h0, PLC_RESP_SLVERR);
        wr(8'hfc, 32'h1, PLC_RESP_SLVERR);
        check(pin_oe, 32'h0);
        // pull control and mutual exclusion
        r = $urandom;
        wr(PLC_PU_EN, r);
        rd(PLC_PU_STATUS, ~r);
        wr(PLC_PD_EN, 32'hffff_ffff);
        rd(PLC_PD_STATUS, r);
        check({pu_on, pd_on}, {r, ~r});
        wr(PLC_PU_EN, 32'hffff_ffff);
        rd(PLC_PU_STATUS, ~r);
        wr(PLC_PD_DIS, 32'hffff_ffff);
        wr(PLC_PU_DIS, r);
        rd(PLC_PU_STATUS, 32'hffff_ffff);
        wr(PLC_PU_EN, 32'hffff_ffff);
        rd(PLC_PU_STATUS, 32'h0);
        // input readback, every line pulled up, the controller driving nothing and ext_oe lines driven externally
        r = $urandom;
        m = $urandom;
        ext_val <= r;
        ext_oe  <= m;
        ev = ~m | r;
        repeat (4) @(posedge aclk);
        rd(PLC_PIN_STATUS, ev);
        check(periph_in, ev);
        clk_on <= 1'b0;
        repeat (2) @(posedge aclk);
        ext_val <= ~r;
        repeat (4) @(posedge aclk);
        rd(PLC_PIN_STATUS, ev);
        clk_on <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(PLC_PIN_STATUS, ~m | ~r);
        // ownership, then output state preset while peripheral owned
        wr(PLC_LINE_CTRL_DIS, 32'hffff_ffff);
        rd(PLC_OWN_STATUS, ~MUXED);
        wr(PLC_LINE_CTRL_EN, 32'h0100_000f);
        rd(PLC_OWN_STATUS, ~MUXED | 32'hf);
        wr(PLC_LINE_CTRL_DIS, 32'hffff_ffff);
        v = $urandom;
        m = $urandom;
        wr(PLC_OE_SET, v);
        wr(PLC_OE_CLR, m);
        oe = v & ~m;
        rd(PLC_OE_STATUS, oe);
        v = $urandom;
        m = $urandom;
        wr(PLC_OD_SET, v);
        wr(PLC_OD_CLR, m);
        od = v & ~m;
        rd(PLC_OD_STATUS, od);
        m = $urandom;
        wr(PLC_WMASK_EN, m);
        wr(PLC_WMASK_DIS, 32'h0000_00ff);
        m = m & 32'hffff_ff00;
        rd(PLC_WMASK_STATUS, m);
        v = $urandom;
        wr(PLC_OD_STATUS, v);
        od = (od & ~m) | (v & m);
        rd(PLC_OD_STATUS, od);
        v = $urandom;
        wr(PLC_MD_EN, v);
        wr(PLC_MD_DIS, v & MUXED);
        md = v & ~MUXED;
        rd(PLC_MD_STATUS, md);
        // every function code, random peripheral drive
        for (int f = 0; f < 4; f++) begin
            wr(PLC_FSEL_LO, {32{f[0]}});
            wr(PLC_FSEL_HI, {32{f[1]}});
            rd(PLC_FSEL_LO, {32{f[0]}});
            po = {$urandom, $urandom, $urandom, $urandom};
            pe = {$urandom, $urandom, $urandom, $urandom};
            p_out <= po;
            p_oe  <= pe;
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            e_oe = {oe[31:24] & ~(md[31:24] & od[31:24]), pe[f][23:0] & PRES[f][23:0]};
            check(pin_oe, e_oe);
            check(pin_out & e_oe, {od[31:24] & ~md[31:24], po[f][23:0]} & e_oe);
        end
        // interrupt only with the clock running
        @(posedge aclk);
        clk_on    <= 1'b0;
        event_irq <= 1'b1;
        repeat (3) @(posedge aclk);
        clk_on <= 1'b1;
        @(negedge aclk);
        check(irq, 1'b0);
        @(negedge aclk);
        check(irq, 1'b1);
        repeat (4) @(posedge aclk);
        check(exp_q.size(), 0);
        report_and_stop();
    end
endmodule : parallel_io_line_controller_tb

// ===== tb/plc_pin_model.sv
/*
 * Pin environment of the line controller: resolves each line from the
 * controller drive, an external driver and the pull resistors.
 * Assumes the bench drives ext_val/ext_oe in the aclk domain.
 */
`timescale 1ns/1ps
module plc_pin_model (
    input  wire logic        aclk,    // clock of the float pattern
    input  wire logic [31:0] pin_out, // controller value
    input  wire logic [31:0] pin_oe,  // controller drive enable
    input  wire logic [31:0] pu_on,   // pull-up on
    input  wire logic [31:0] pd_on,   // pull-down on
    input  wire logic [31:0] ext_val, // external value
    input  wire logic [31:0] ext_oe,  // external drive enable
    output logic      [31:0] lvl      // resolved line level
);
    logic [31:0] float_q = 32'h5555_5555;

    // a line nobody holds must not look like a stable value
    always @(posedge aclk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe[i] || ext_oe[i])
                lvl[i] = (pin_oe[i] ? pin_out[i] : 1'b1) & (ext_oe[i] ? ext_val[i] : 1'b1);
            else if (pu_on[i])
                lvl[i] = 1'b1;
            else if (pd_on[i])
                lvl[i] = 1'b0;
            else
                lvl[i] = float_q[i];
        end
    end
endmodule : plc_pin_model
